// ==== logic/hcsr_regs.sv ====
// host-visible configuration, bus error and station address registers
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - writing one clears flag, zero leaves it
// - offsets 00-05, 0A-0F, 16-1F are reserved
// - illegal byte enables set sticky flag bit 15
// - bits 14..11 report offending byte enables 3..0
// - clock strap latched into bit 10 (endianness)
// - prom enable strap latched into bit 9
// - bits 7,6 width from prom or strap; bit 5 32-bit
// - bit 3 is package size; 8,4,2,1,0 read zero
// - address fetched from prom only when enabled
// - prom fetch starts at word 1 after reset
// - words 1,2,3 load low, middle, high registers
// - address registers host read/write, prom untouched
// - low register least, high register most significant
// - bus clock control defaults to 125 MHz, adjustable
module hcsr_regs
  import hcsr_pkg::*;
#(
  parameter bit IS_32BIT    = 1'b0,
  parameter bit PKG_128PIN  = 1'b1
)(
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // host register port
  input  wire logic [7:0]  host_addr_in,
  input  wire logic [3:0]  host_be_in,
  input  wire logic        host_rd_in,
  input  wire logic        host_wr_in,
  input  wire logic [31:0] host_wdata_in,
  output logic [31:0]      host_rdata_out,
  // strap pins
  input  wire logic        serial_prom_clock_strap_in,
  input  wire logic        serial_prom_enable_strap_in,
  input  wire logic        serial_prom_data_in_strap_in,
  // serial prom word port
  output logic             prom_req_out,
  output logic [5:0]       prom_word_out,
  input  wire logic        prom_ack_in,
  input  wire logic [15:0] prom_data_in,
  // block outputs
  output logic [47:0]      station_address_out,
  output logic             little_endian_out,
  output logic             drive_strength_out,
  output logic             bus_clk_en_out,
  output logic             prom_load_busy_out
);

  // elaboration check: divider assumes core clock equals default bus clock
  if (HCSR_DIV_BASE != 1) begin : g_bad_clk
    $error("hcsr_regs: core clock must equal the default bus clock");
  end

  // strap synchronisers
  logic [2:0] strap_s1_q;
  logic [2:0] strap_s2_q;
  logic [1:0] settle_q;
  logic       capture;

  always_ff @(posedge mclk_in) begin
    strap_s1_q <= {serial_prom_data_in_strap_in, serial_prom_enable_strap_in, serial_prom_clock_strap_in};
    strap_s2_q <= strap_s1_q;
  end

  // capture once the synchronisers hold post-release pin levels
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      settle_q <= 2'h0;
    end else if (settle_q != HCSR_STRAP_SETTLE) begin
      settle_q <= settle_q + 2'h1;
    end
  end
  assign capture = (settle_q == (HCSR_STRAP_SETTLE - 2'h1));

  // host access decode
  logic        access;
  logic        legal;
  logic        bad;
  logic [5:0]  dword;
  logic [31:0] wmask;

  assign access = host_rd_in | host_wr_in;
  assign legal  = hcsr_be_legal(host_be_in);
  assign bad    = access & ~legal;
  assign dword  = host_addr_in[7:2];
  assign wmask  = {{8{host_be_in[3]}}, {8{host_be_in[2]}}, {8{host_be_in[1]}}, {8{host_be_in[0]}}};

  // write hit on the 16-bit register at byte offset off
  function automatic logic wr_hit(input logic [7:0] off);
    wr_hit = host_wr_in && legal && (dword == off[7:2]) && (off[1] ? |host_be_in[3:2] : |host_be_in[1:0]);
  endfunction

  // merge the written lanes into a 16-bit register value
  function automatic logic [15:0] merge(input logic [7:0] off, input logic [15:0] cur);
    logic [15:0] m;
    logic [15:0] d;
    m = off[1] ? wmask[31:16] : wmask[15:0];
    d = off[1] ? host_wdata_in[31:16] : host_wdata_in[15:0];
    merge = (cur & ~m) | (d & m);
  endfunction

  // bus error status
  logic       flag_q;
  logic [3:0] lanes_q;
  logic       clr;
  logic [15:0] bes_wr;

  // functions read bus signals directly, so a process sees every change
  always_comb begin
    bes_wr = merge(HCSR_OFF_BUS_ERR, HCSR_RST_WORD);
    clr    = wr_hit(HCSR_OFF_BUS_ERR) && bes_wr[HCSR_BES_FLAG_BIT];
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= bad | (flag_q & ~clr);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      lanes_q <= HCSR_RST_LANES;
    end else if (bad && (!flag_q || clr)) begin
      lanes_q <= host_be_in;
    end
  end

  // chip configuration
  logic       endian_q;
  logic       prom_en_q;
  logic       w8_q;
  logic       w16_q;
  logic [15:0] cfg_word;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      endian_q  <= 1'b0;
      prom_en_q <= 1'b0;
    end else if (capture) begin
      endian_q  <= strap_s2_q[0];
      prom_en_q <= strap_s2_q[1];
    end
  end

  // prom loader
  logic        ld_start;
  logic        ld_wr;
  logic [1:0]  ld_sel;
  logic [15:0] ld_data;

  assign ld_start = capture && strap_s2_q[1];

  hcsr_prom_loader u_loader (
    .mclk_in       (mclk_in),
    .rst_in        (rst_in),
    .start_in      (ld_start),
    .busy_out      (prom_load_busy_out),
    .prom_req_out  (prom_req_out),
    .prom_word_out (prom_word_out),
    .prom_ack_in   (prom_ack_in),
    .prom_data_in  (prom_data_in),
    .ld_wr_out     (ld_wr),
    .ld_sel_out    (ld_sel),
    .ld_data_out   (ld_data)
  );

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      w8_q  <= 1'b0;
      w16_q <= 1'b0;
    end else if (capture && !strap_s2_q[1]) begin
      w8_q  <= ~strap_s2_q[2];
      w16_q <= strap_s2_q[2];
    end else if (ld_wr && (ld_sel == HCSR_PROM_WORDS)) begin
      w8_q  <= ld_data[HCSR_CFG_W8_BIT];
      w16_q <= ld_data[HCSR_CFG_W16_BIT];
    end
  end

  always_comb begin
    cfg_word                      = HCSR_RST_WORD;
    cfg_word[HCSR_CFG_ENDIAN_BIT] = endian_q;
    cfg_word[HCSR_CFG_PROM_BIT]   = prom_en_q;
    cfg_word[HCSR_CFG_W8_BIT]     = w8_q;
    cfg_word[HCSR_CFG_W16_BIT]    = w16_q;
    cfg_word[HCSR_CFG_W32_BIT]    = IS_32BIT;
    cfg_word[HCSR_CFG_PKG_BIT]    = PKG_128PIN;
  end

  // station address: index 0 low, 1 middle, 2 high
  logic [15:0] sa_q [3];
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sa
      localparam logic [7:0] OFF = HCSR_OFF_SA_LOW + 8'(2 * gi);
      always_ff @(posedge mclk_in) begin
        if (rst_in) begin
          sa_q[gi] <= HCSR_RST_WORD;
        end else if (ld_wr && (ld_sel == 2'(gi))) begin
          sa_q[gi] <= ld_data;
        end else if (wr_hit(OFF)) begin
          sa_q[gi] <= merge(OFF, sa_q[gi]);
        end
      end
    end
  endgenerate
  assign station_address_out = {sa_q[2], sa_q[1], sa_q[0]};

  // internal bus clock control
  logic [15:0] bcc_q;
  logic [1:0]  div_cnt_q;
  logic [1:0]  div_last;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      bcc_q <= HCSR_RST_WORD;
    end else if (wr_hit(HCSR_OFF_BUS_CLK)) begin
      bcc_q <= merge(HCSR_OFF_BUS_CLK, bcc_q) & HCSR_BCC_WR_MASK;
    end
  end
  assign drive_strength_out = bcc_q[HCSR_BCC_DRIVE_BIT];
  assign little_endian_out  = endian_q;

  // reserved divider code and reserved source fall back to divide by one
  assign div_last = (bcc_q[HCSR_BCC_SEL_BIT] || (bcc_q[HCSR_BCC_DIV_LSB +: 2] == 2'h3)) ? 2'h0
                  : bcc_q[HCSR_BCC_DIV_LSB +: 2];

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      div_cnt_q <= HCSR_RST_DIV;
    end else if (div_cnt_q >= div_last) begin
      div_cnt_q <= HCSR_RST_DIV;
    end else begin
      div_cnt_q <= div_cnt_q + 2'h1;
    end
  end
  assign bus_clk_en_out = (div_cnt_q >= div_last);

  // register read
  function automatic logic [15:0] rd16(input logic [7:0] off);
    case (off)
      HCSR_OFF_BUS_ERR:  rd16 = {flag_q, lanes_q, 11'h000};
      HCSR_OFF_CHIP_CFG: rd16 = cfg_word;
      HCSR_OFF_SA_LOW:   rd16 = sa_q[0];
      HCSR_OFF_SA_MID:   rd16 = sa_q[1];
      HCSR_OFF_SA_HIGH:  rd16 = sa_q[2];
      HCSR_OFF_BUS_CLK:  rd16 = bcc_q;
      default:           rd16 = HCSR_RST_WORD;
    endcase
  endfunction

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      host_rdata_out <= 32'h0000_0000;
    end else if (host_rd_in && legal) begin
      host_rdata_out <= {rd16({dword, 2'b10}), rd16({dword, 2'b00})} & wmask;
    end
  end

  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  logic bes_w32;
  assign bes_w32 = host_wr_in && (host_be_in == 4'hC) && (dword == HCSR_OFF_BUS_ERR[7:2]);

  AST_W1C_CLEAR: assert property (bes_w32 && host_wdata_in[31] |=> !flag_q)
    else $error("flag not cleared by writing one");
  AST_W0_KEEP: assert property (flag_q && bes_w32 && !host_wdata_in[31] |=> flag_q)
    else $error("flag lost on writing zero");
  AST_RSVD_READ: assert property (host_rd_in && (host_be_in == 4'hF) && (dword == 6'h00 || dword == 6'h06)
                                   |=> host_rdata_out == 32'h0000_0000)
    else $error("reserved location read non-zero");
  AST_BAD_SETS: assert property (bad |=> flag_q ##1 (flag_q || $past(clr)))
    else $error("illegal byte enables did not set flag");
  AST_LANES_CAPTURE: assert property (bad && !flag_q |=> lanes_q == $past(host_be_in))
    else $error("offending byte enables not captured");
  AST_LANES_HOLD: assert property (flag_q && !clr |=> $stable(lanes_q))
    else $error("captured byte enables changed while flag set");
  AST_STRAP_LATCH: assert property (capture |=> little_endian_out == $past(strap_s2_q[0])
                                     && cfg_word[HCSR_CFG_PROM_BIT] == $past(strap_s2_q[1]))
    else $error("strap levels not latched");
  AST_NO_PROM_NO_LOAD: assert property (capture && !strap_s2_q[1] |=> !prom_req_out [*8])
    else $error("prom fetched without enable strap");
  AST_SA_LOAD: assert property (ld_wr && ld_sel == 2'h0 |=> station_address_out[15:0] == $past(ld_data))
    else $error("low address word not loaded from prom");
  AST_DIV_TWO: assert property (bcc_q[2:0] == 3'h1 && bus_clk_en_out && $stable(bcc_q) && !host_wr_in
                                 ##1 !host_wr_in |-> !bus_clk_en_out ##1 bus_clk_en_out)
    else $error("divide by two enable spacing wrong");

endmodule // hcsr_regs
`default_nettype wire

// ==== logic/hcsr_pkg.sv ====
// constants for the host configuration and status register bank
`default_nettype none
package hcsr_pkg;

  // register byte offsets
  localparam logic [7:0]  HCSR_OFF_BUS_ERR   = 8'h06;
  localparam logic [7:0]  HCSR_OFF_CHIP_CFG  = 8'h08;
  localparam logic [7:0]  HCSR_OFF_SA_LOW    = 8'h10;
  localparam logic [7:0]  HCSR_OFF_SA_MID    = 8'h12;
  localparam logic [7:0]  HCSR_OFF_SA_HIGH   = 8'h14;
  localparam logic [7:0]  HCSR_OFF_BUS_CLK   = 8'h20;

  // bus_error_status fields
  localparam int          HCSR_BES_FLAG_BIT  = 15;
  localparam int          HCSR_BES_VAL_LSB   = 11;

  // chip_configuration fields
  localparam int          HCSR_CFG_ENDIAN_BIT = 10;
  localparam int          HCSR_CFG_PROM_BIT   = 9;
  localparam int          HCSR_CFG_W8_BIT     = 7;
  localparam int          HCSR_CFG_W16_BIT    = 6;
  localparam int          HCSR_CFG_W32_BIT    = 5;
  localparam int          HCSR_CFG_PKG_BIT    = 3;

  // internal_bus_clock_control fields
  localparam int          HCSR_BCC_DRIVE_BIT = 6;
  localparam int          HCSR_BCC_SEL_BIT   = 2;
  localparam int          HCSR_BCC_DIV_LSB   = 0;
  localparam logic [15:0] HCSR_BCC_WR_MASK   = 16'h0047;

  // reset values
  localparam logic [15:0] HCSR_RST_WORD      = 16'h0000;
  localparam logic [3:0]  HCSR_RST_LANES     = 4'h0;
  localparam logic [1:0]  HCSR_RST_DIV       = 2'h0;

  // serial prom word map
  localparam logic [5:0]  HCSR_PROM_SA_FIRST = 6'h01;
  localparam logic [5:0]  HCSR_PROM_CFG_WORD = 6'h00;
  localparam logic [1:0]  HCSR_PROM_WORDS    = 2'h3;

  // timing
  localparam int          HCSR_CLK_MHZ       = 125;
  localparam int          HCSR_BUS_CLK_MHZ   = 125;
  localparam int          HCSR_DIV_BASE      = HCSR_CLK_MHZ / HCSR_BUS_CLK_MHZ;
  localparam logic [1:0]  HCSR_STRAP_SETTLE  = 2'h3;

  // loader states, gray order
  typedef enum logic [1:0] {
    HCSR_LD_IDLE = 2'b00,
    HCSR_LD_REQ  = 2'b01,
    HCSR_LD_DONE = 2'b11
  } hcsr_ld_state_t;

  // single lanes, aligned pairs and all four are legal
  function automatic logic hcsr_be_legal(input logic [3:0] be);
    case (be)
      4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF: hcsr_be_legal = 1'b1;
      default:                                  hcsr_be_legal = 1'b0;
    endcase
  endfunction

endpackage
`default_nettype wire

// ==== logic/hcsr_prom_loader.sv ====
// sequencer that fetches station address and width words from the serial prom
`timescale 1ns/100ps
`default_nettype none
module hcsr_prom_loader
  import hcsr_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // control
  input  wire logic        start_in,
  output logic             busy_out,
  // prom word port
  output logic             prom_req_out,
  output logic [5:0]       prom_word_out,
  input  wire logic        prom_ack_in,
  input  wire logic [15:0] prom_data_in,
  // register load strobe
  output logic             ld_wr_out,
  output logic [1:0]       ld_sel_out,
  output logic [15:0]      ld_data_out
);

  hcsr_ld_state_t state_q;
  logic [1:0]     idx_q;

  assign busy_out      = (state_q == HCSR_LD_REQ);
  assign prom_req_out  = (state_q == HCSR_LD_REQ);
  // words 1..3 first, configuration word last
  assign prom_word_out = (idx_q == HCSR_PROM_WORDS) ? HCSR_PROM_CFG_WORD
                       : HCSR_PROM_SA_FIRST + {4'h0, idx_q};

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_q <= HCSR_LD_IDLE;
      idx_q   <= 2'h0;
    end else begin
      case (state_q)
        HCSR_LD_IDLE: begin
          if (start_in) begin
            state_q <= HCSR_LD_REQ;
            idx_q   <= 2'h0;
          end
        end
        HCSR_LD_REQ: begin
          if (prom_ack_in) begin
            if (idx_q == HCSR_PROM_WORDS) begin
              state_q <= HCSR_LD_DONE;
            end
            idx_q <= idx_q + 2'h1;
          end
        end
        HCSR_LD_DONE: state_q <= HCSR_LD_DONE;
        default:      state_q <= HCSR_LD_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ld_wr_out   <= 1'b0;
      ld_sel_out  <= 2'h0;
      ld_data_out <= HCSR_RST_WORD;
    end else begin
      ld_wr_out <= (state_q == HCSR_LD_REQ) && prom_ack_in;
      if ((state_q == HCSR_LD_REQ) && prom_ack_in) begin
        ld_sel_out  <= idx_q;
        ld_data_out <= prom_data_in;
      end
    end
  end

endmodule // hcsr_prom_loader
`default_nettype wire

// ==== testbench/hcsr_prom_model.sv ====
// serial prom engine model answering word requests after a set latency
`timescale 1ns/100ps
`default_nettype none
module hcsr_prom_model #(
  parameter logic [15:0] WORD0 = 16'h0080,
  parameter logic [15:0] WORD1 = 16'h3C21,
  parameter logic [15:0] WORD2 = 16'h7A55,
  parameter logic [15:0] WORD3 = 16'h0F96
)(
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // word port
  input  wire logic        prom_req_in,
  input  wire logic [5:0]  prom_word_in,
  input  wire logic [3:0]  lat_in,
  output logic             prom_ack_out,
  output logic [15:0]      prom_data_out
);
  logic [3:0] wait_q;

  function automatic logic [15:0] word_at(input logic [5:0] w);
    case (w)
      6'h00:   word_at = WORD0;
      6'h01:   word_at = WORD1;
      6'h02:   word_at = WORD2;
      6'h03:   word_at = WORD3;
      default: word_at = 16'h0000;
    endcase
  endfunction

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      prom_ack_out  <= 1'b0;
      wait_q        <= 4'h0;
      prom_data_out <= 16'hA5A5;
    end else if (!prom_ack_out && prom_req_in && wait_q >= lat_in) begin
      prom_ack_out  <= 1'b1;
      prom_data_out <= word_at(prom_word_in);
      wait_q        <= 4'h0;
    end else begin
      // data is garbage outside the ack cycle
      prom_ack_out  <= 1'b0;
      prom_data_out <= ~prom_data_out;
      wait_q        <= (prom_req_in && !prom_ack_out) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule // hcsr_prom_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the host configuration and status register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import hcsr_pkg::*;
  logic        mclk_in;
  logic        rst_in;
  logic [7:0]  addr;
  logic [3:0]  be;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        strap_clk;
  logic        strap_en;
  logic        strap_din;
  logic        req;
  logic [5:0]  word;
  logic        ack;
  logic [15:0] pdata;
  logic [3:0]  lat;
  logic [47:0] sa;
  logic        le;
  logic        drv;
  logic        clk_en;
  logic        busy;
  logic [5:0]  wlog[$];
  int          errors;
  int          check_count;

  hcsr_regs u_hcsr_regs (
    .mclk_in(mclk_in), .rst_in(rst_in), .host_addr_in(addr), .host_be_in(be), .host_rd_in(rd),
    .host_wr_in(wr), .host_wdata_in(wdata), .host_rdata_out(rdata), .serial_prom_clock_strap_in(strap_clk),
    .serial_prom_enable_strap_in(strap_en), .serial_prom_data_in_strap_in(strap_din), .prom_req_out(req),
    .prom_word_out(word), .prom_ack_in(ack), .prom_data_in(pdata), .station_address_out(sa),
    .little_endian_out(le), .drive_strength_out(drv), .bus_clk_en_out(clk_en), .prom_load_busy_out(busy));

  hcsr_prom_model u_hcsr_prom_model (
    .mclk_in(mclk_in), .rst_in(rst_in), .prom_req_in(req), .prom_word_in(word), .lat_in(lat),
    .prom_ack_out(ack), .prom_data_out(pdata));

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    if (req === 1'b1 && ack === 1'b1) begin
      wlog.push_back(word);
    end
  end

  task automatic finish_test();
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic [3:0] b, input logic w, input logic [31:0] d);
    @(posedge mclk_in);
    addr  <= a;
    be    <= b;
    wr    <= w;
    rd    <= ~w;
    wdata <= d;
    @(posedge mclk_in);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk_in);
    #1;
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    bus(a, a[1] ? 4'hC : 4'h3, 1'b1, a[1] ? {v, 16'h0000} : {16'h0000, v});
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    bus(a, a[1] ? 4'hC : 4'h3, 1'b0, 32'h0000_0000);
    v = a[1] ? rdata[31:16] : rdata[15:0];
  endtask

  task automatic do_reset(input logic c, input logic e, input logic d, input logic [3:0] l);
    @(posedge mclk_in);
    rst_in    <= 1'b1;
    strap_clk <= c;
    strap_en  <= e;
    strap_din <= d;
    lat       <= l;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    wlog.delete();
    repeat (8) @(posedge mclk_in);
  endtask

  task automatic t_no_prom();
    logic [15:0] v;
    do_reset(1'b1, 1'b0, 1'b1, 4'h0);
    rd16(HCSR_OFF_CHIP_CFG, v);
    check("cfg", v, 16'h0448);
    check("little_endian", le, 1'b1);
    check("prom words", wlog.size(), 0);
    check("sa reset", sa, 48'h0);
    rd16(HCSR_OFF_BUS_CLK, v);
    check("bus clk default", v, 16'h0000);
  endtask

  task automatic t_reserved();
    logic [7:0]  offs[5] = '{8'h00, 8'h04, 8'h0C, 8'h18, 8'h1C};
    logic [15:0] v;
    foreach (offs[i]) begin
      bus(offs[i], 4'hF, 1'b1, 32'hFFFF_FFFF);
      bus(offs[i], 4'hF, 1'b0, 32'h0000_0000);
      check("reserved read", rdata & (offs[i] == 8'h04 ? 32'h0000_FFFF : 32'hFFFF_FFFF), 32'h0);
    end
    wr16(HCSR_OFF_CHIP_CFG, 16'hFFFF);
    rd16(HCSR_OFF_CHIP_CFG, v);
    check("cfg read only", v, 16'h0448);
  endtask

  task automatic t_station();
    logic [15:0] v;
    wr16(HCSR_OFF_SA_LOW, 16'h1122);
    wr16(HCSR_OFF_SA_MID, 16'h3344);
    wr16(HCSR_OFF_SA_HIGH, 16'h5566);
    rd16(HCSR_OFF_SA_MID, v);
    check("sa mid", v, 16'h3344);
    check("sa out", sa, 48'h5566_3344_1122);
    check("prom untouched", wlog.size(), 0);
  endtask

  task automatic t_bad_lanes();
    logic [15:0] v;
    bus(HCSR_OFF_SA_LOW, 4'h5, 1'b1, 32'hFFFF_FFFF);
    rd16(HCSR_OFF_SA_LOW, v);
    check("ignored write", v, 16'h1122);
    rd16(HCSR_OFF_BUS_ERR, v);
    check("flag and value", v, 16'hA800);
    bus(HCSR_OFF_SA_LOW, 4'h6, 1'b0, 32'h0000_0000);
    wr16(HCSR_OFF_BUS_ERR, 16'h0000);
    rd16(HCSR_OFF_BUS_ERR, v);
    check("value held", v, 16'hA800);
    wr16(HCSR_OFF_BUS_ERR, 16'h8000);
    rd16(HCSR_OFF_BUS_ERR, v);
    check("flag cleared", v[15], 1'b0);
    bus(HCSR_OFF_SA_LOW, 4'h6, 1'b1, 32'h0000_0000);
    rd16(HCSR_OFF_BUS_ERR, v);
    check("recapture", v, 16'hB000);
  endtask

  task automatic t_bus_clk();
    logic [15:0] v;
    logic [15:0] codes[4] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004};
    int          exp[4] = '{6, 4, 12, 12};
    int          n;
    foreach (codes[i]) begin
      rd16(HCSR_OFF_BUS_CLK, v);
      wr16(HCSR_OFF_BUS_CLK, (v & ~HCSR_BCC_WR_MASK) | codes[i]);
      n = 0;
      repeat (12) begin
        @(posedge mclk_in);
        #1;
        n += (clk_en === 1'b1);
      end
      check("clk enables", n, exp[i]);
    end
    wr16(HCSR_OFF_BUS_CLK, 16'hFFFF);
    rd16(HCSR_OFF_BUS_CLK, v);
    check("bus clk mask", v, 16'h0047);
    check("drive strength", drv, 1'b1);
  endtask

  task automatic t_prom_load(input logic [3:0] l);
    logic [15:0] v;
    int          k;
    do_reset(1'b0, 1'b1, 1'b0, l);
    k = 0;
    while (busy !== 1'b0 && k < 300) begin
      @(posedge mclk_in);
      k++;
    end
    repeat (3) @(posedge mclk_in);
    #1;
    check("load done", busy, 1'b0);
    check("word count", wlog.size(), 48'd4);
    check("word order", {wlog[0], wlog[1], wlog[2], wlog[3]}, 24'h04_20C0);
    check("big endian", le, 1'b0);
    check("sa loaded", sa, 48'h0F96_7A55_3C21);
    rd16(HCSR_OFF_SA_HIGH, v);
    check("sa high", v, 16'h0F96);
    rd16(HCSR_OFF_CHIP_CFG, v);
    check("cfg prom", v, 16'h0288);
  endtask

  initial begin
    rst_in = 1'b1;
    addr = 8'h00;
    be = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0000_0000;
    strap_clk = 1'b1;
    strap_en = 1'b0;
    strap_din = 1'b1;
    lat = 4'h0;
    errors = 0;
    check_count = 0;
    repeat (3) @(posedge mclk_in);
    t_no_prom();
    t_reserved();
    t_station();
    t_bad_lanes();
    t_bus_clk();
    t_prom_load(4'h0);
    t_prom_load(4'h5);
    finish_test();
  end

  initial begin
    #100000;
    errors++;
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
